// File: trsl_map.vh
// Constants for the torque reference and torque-mode speed limit block
//
// Behaviour
// - Torque command follows signed reference in torque mode
// - Factory gain: plus three volts gives rated torque
// - Auto offset measures input and stores the correction
// - Auto offset adjust only allowed with servo off
// - Manual offset stores operator value like auto
// - Select zero internal cap, one lower of both
// - Internal cap 0 to 6000 rpm, default 1500
// - Internal cap above motor maximum uses motor maximum
// - External selected: smaller of analog and internal
// - External limit uses analog magnitude, sign ignored
// - Speed gain rpm per volt, 0 to 3000, default 150
`ifndef TRSL_MAP_VH
`define TRSL_MAP_VH

// Torque gain, unit 0.1 V per rated torque
`define TRSL_TREF_GAIN_MIN      7'h0a
`define TRSL_TREF_GAIN_MAX      7'h64
`define TRSL_TREF_GAIN_FACTORY  7'h1e
// mV * 10 / gain gives torque in 0.1 % of rated
`define TRSL_TREF_SCALE         16'h000a
// Internal speed cap in rpm
`define TRSL_SPEED_CAP_MAX      13'h1770
`define TRSL_SPEED_CAP_FACTORY  13'h05dc
// Speed gain in rpm per volt
`define TRSL_SPEED_GAIN_MAX     12'hbb8
`define TRSL_SPEED_GAIN_FACTORY 12'h096
// Millivolts per volt
`define TRSL_MV_PER_V           10'h3e8
// Speed limit source selector values
`define TRSL_SEL_INTERNAL       1'b0
`define TRSL_SEL_EXTERNAL       1'b1
// Saturation, zero and reset values
`define TRSL_TORQUE_POS_MAX     16'h7fff
`define TRSL_TORQUE_ZERO        16'h0000
`define TRSL_SPEED_SAT          13'h1fff
`define TRSL_OFFSET_RESET       16'h0000

`endif

// File: trsl_div.v
// Serial restoring divider for unsigned operands
`default_nettype none

module trsl_div #(
	parameter NW = 20,             // Numerator width
	parameter DW = 7               // Divisor width
) (
	input  wire          clk,      // System clock
	input  wire          rst,      // Asynchronous reset, active high
	input  wire          start,    // Begin a division when idle
	input  wire [NW-1:0] num,      // Dividend
	input  wire [DW-1:0] den,      // Divisor, zero gives all ones
	output reg           busy,     // Division in progress
	output reg           done,     // One-cycle pulse, quo valid
	output reg  [NW-1:0] quo       // Quotient register
);

	localparam CW = $clog2(NW + 1);

	reg  [DW-1:0] rem;
	reg  [CW-1:0] cnt;
	wire [DW:0]   shifted = {rem, quo[NW-1]};
	wire          fits    = shifted >= {1'b0, den};
	wire [DW:0]   diff    = shifted - {1'b0, den};

	// One quotient bit per cycle keeps the area of a single subtractor
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			done <= 1'b0;
			quo  <= {NW{1'b0}};
			rem  <= {DW{1'b0}};
			cnt  <= {CW{1'b0}};
		end else begin
			done <= 1'b0;
			if (!busy && start) begin
				quo  <= num;
				rem  <= {DW{1'b0}};
				cnt  <= NW[CW-1:0];
				busy <= 1'b1;
			end else if (busy) begin
				quo <= {quo[NW-2:0], fits};
				rem <= fits ? diff[DW-1:0] : shifted[DW-1:0];
				cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
				if (cnt == {{(CW-1){1'b0}}, 1'b1}) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule // trsl_div

`default_nettype wire

// File: trsl_core.v
// Torque reference scaling, offset store and torque-mode speed limit
`include "trsl_map.vh"
`default_nettype none

module trsl_core (
	input  wire        sys_clk,               // System clock, 25 MHz
	input  wire        rst,                   // Async reset, active high
	input  wire        torque_mode_active,    // Torque control selected
	input  wire        servo_on,              // Servo enabled
	input  wire [15:0] torque_ref_in,         // Signed torque ref, mV
	input  wire [15:0] speed_ref_in,          // Signed speed input, mV
	input  wire [6:0]  torque_ref_gain,       // 0.1 V per rated torque
	input  wire [12:0] torque_mode_speed_cap, // Internal cap, rpm
	input  wire [11:0] speed_ref_gain,        // rpm per volt
	input  wire        speed_limit_source,    // 0 internal, 1 external
	input  wire [12:0] motor_max_speed,       // Motor maximum, rpm
	input  wire [15:0] motor_speed,           // Signed measured rpm
	input  wire        auto_offset_adjust,    // Pulse: measure offset
	input  wire        manual_offset_adjust,  // Pulse: store entry
	input  wire [15:0] manual_offset_value,   // Signed entry, mV
	output reg  [15:0] torque_cmd,            // Signed, 0.1 % rated
	output reg  [15:0] torque_ref_monitor,    // Scaled ref, no limit
	output reg  [12:0] speed_limit_eff,       // Effective limit, rpm
	output reg         speed_limiting,        // Torque being cut
	output reg  [15:0] offset_value,          // Stored correction, mV
	output reg         offset_refused,        // Pulse: auto refused
	output reg         param_fault            // Setting out of range
);

	////////////////////////////////////////////////////////////////////
	// Helpers

	function [12:0] min13;
		input [12:0] a;
		input [12:0] b;
		begin
			min13 = (a < b) ? a : b;
		end
	endfunction

	function [16:0] abs17;
		input [16:0] v;
		begin
			abs17 = v[16] ? (~v + 17'h0_0001) : v;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Offset store

	// Measuring with the servo on would fold a live command into the
	// correction, so the request is dropped and flagged instead
	// Auto wins when both pulses land in the same cycle
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			offset_value   <= `TRSL_OFFSET_RESET;
			offset_refused <= 1'b0;
		end else begin
			offset_refused <= 1'b0;
			if (auto_offset_adjust) begin
				if (!servo_on) begin
					offset_value <= torque_ref_in;
				end else begin
					offset_refused <= 1'b1;
				end
			end else if (manual_offset_adjust) begin
				offset_value <= manual_offset_value;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Parameter range handling

	// Out-of-range settings are clamped, not ignored, and flagged
	wire [6:0] gain_eff =
		(torque_ref_gain < `TRSL_TREF_GAIN_MIN) ? `TRSL_TREF_GAIN_MIN :
		(torque_ref_gain > `TRSL_TREF_GAIN_MAX) ? `TRSL_TREF_GAIN_MAX :
		torque_ref_gain;
	wire [12:0] cap_clamped =
		min13(torque_mode_speed_cap, `TRSL_SPEED_CAP_MAX);
	wire [11:0] sgain_eff =
		(speed_ref_gain > `TRSL_SPEED_GAIN_MAX) ?
		`TRSL_SPEED_GAIN_MAX : speed_ref_gain;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			param_fault <= 1'b0;
		end else begin
			param_fault <= (torque_ref_gain < `TRSL_TREF_GAIN_MIN) ||
				(torque_ref_gain > `TRSL_TREF_GAIN_MAX) ||
				(torque_mode_speed_cap > `TRSL_SPEED_CAP_MAX) ||
				(speed_ref_gain > `TRSL_SPEED_GAIN_MAX);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Torque reference scaling

	// Offset comes off first, so the gain never scales the error up
	wire [16:0] tq_diff = {torque_ref_in[15], torque_ref_in} -
		{offset_value[15], offset_value};
	wire [16:0] tq_mag  = abs17(tq_diff);
	wire [19:0] tq_num  = {3'b000, tq_mag} *
		{4'h0, `TRSL_TREF_SCALE};
	wire        tq_busy;
	wire        tq_done;
	wire [19:0] tq_quo;
	reg         tq_neg;
	reg  [6:0]  tq_den;

	trsl_div #(
		.NW (20),
		.DW (7)
	) u_tq_div (
		.clk   (sys_clk),
		.rst   (rst),
		.start (!tq_busy),
		.num   (tq_num),
		.den   (tq_den),
		.busy  (tq_busy),
		.done  (tq_done),
		.quo   (tq_quo)
	);

	wire [15:0] tq_sat = (tq_quo[19:15] != 5'h00) ?
		`TRSL_TORQUE_POS_MAX : tq_quo[15:0];

	// Sign and divisor are held per conversion, so a gain change mid-way
	// cannot mix two gains; the result edge still sees the old sign
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tq_neg             <= 1'b0;
			tq_den             <= `TRSL_TREF_GAIN_MIN;
			torque_ref_monitor <= `TRSL_TORQUE_ZERO;
		end else begin
			if (!tq_busy) begin
				tq_neg <= tq_diff[16];
				tq_den <= gain_eff;
			end
			if (tq_done) begin
				torque_ref_monitor <= tq_neg ?
					(~tq_sat + 16'h0001) : tq_sat;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// External speed limit from the analog speed input

	wire [16:0] sp_mag = abs17({speed_ref_in[15], speed_ref_in});
	wire [27:0] sp_num = {11'h000, sp_mag} * {16'h0000, sgain_eff};
	wire        sp_busy;
	wire        sp_done;
	wire [27:0] sp_quo;
	reg  [12:0] ext_limit;

	trsl_div #(
		.NW (28),
		.DW (10)
	) u_sp_div (
		.clk   (sys_clk),
		.rst   (rst),
		.start (!sp_busy),
		.num   (sp_num),
		.den   (`TRSL_MV_PER_V),
		.busy  (sp_busy),
		.done  (sp_done),
		.quo   (sp_quo)
	);

	// Saturated until the first result, so the external source cannot
	// undercut the internal cap straight out of reset
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ext_limit <= `TRSL_SPEED_SAT;
		end else if (sp_done) begin
			ext_limit <= (sp_quo[27:13] != 15'h0000) ?
				`TRSL_SPEED_SAT : sp_quo[12:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Effective limit and torque cut

	// Motor maximum bounds both sources, the external one through this
	wire [12:0] int_limit = min13(cap_clamped, motor_max_speed);
	wire [12:0] next_speed_limit_eff =
		(speed_limit_source == `TRSL_SEL_EXTERNAL) ?
		min13(ext_limit, int_limit) : int_limit;

	// Magnitude test: the cap is the same in both directions
	wire [16:0] spd_abs  = abs17({motor_speed[15], motor_speed});
	wire        at_limit = spd_abs >= {4'h0, speed_limit_eff};
	wire        tq_pos   = !torque_ref_monitor[15] &&
		(torque_ref_monitor != `TRSL_TORQUE_ZERO);
	wire        tq_rev   = torque_ref_monitor[15];
	// Only torque that pushes further past the limit is removed, so the
	// motor may still brake from an overspeed
	wire        next_speed_limiting = torque_mode_active && at_limit &&
		((!motor_speed[15] && tq_pos) ||
		(motor_speed[15] && tq_rev));

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			speed_limit_eff <= `TRSL_SPEED_CAP_FACTORY;
			speed_limiting  <= 1'b0;
			torque_cmd      <= `TRSL_TORQUE_ZERO;
		end else begin
			speed_limit_eff <= next_speed_limit_eff;
			speed_limiting  <= next_speed_limiting;
			if (!torque_mode_active || next_speed_limiting) begin
				torque_cmd <= `TRSL_TORQUE_ZERO;
			end else begin
				torque_cmd <= torque_ref_monitor;
			end
		end
	end

endmodule // trsl_core

`default_nettype wire

// File: trsl_monitor.sv
// Assertion checker for the torque reference and speed limit block
`include "trsl_map.vh"
`default_nettype none
module trsl_monitor (
	input wire logic        sys_clk,               // Clock
	input wire logic        rst,                   // Reset
	input wire logic        torque_mode_active,    // Mode
	input wire logic        servo_on,              // Servo
	input wire logic [15:0] torque_ref_in,         // Reference
	input wire logic [12:0] torque_mode_speed_cap, // Cap
	input wire logic        speed_limit_source,    // Source
	input wire logic [12:0] motor_max_speed,       // Motor max
	input wire logic        auto_offset_adjust,    // Auto
	input wire logic        manual_offset_adjust,  // Manual
	input wire logic [15:0] manual_offset_value,   // Entry
	input wire logic [15:0] torque_cmd,            // Command
	input wire logic [15:0] torque_ref_monitor,    // Monitor
	input wire logic [12:0] speed_limit_eff,       // Limit
	input wire logic        speed_limiting,        // Cut
	input wire logic [15:0] offset_value,          // Offset
	input wire logic        offset_refused,        // Refused
	input wire logic        param_fault            // Fault
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [12:0] cap_c;
	logic [12:0] int_lim;
	assign cap_c = (torque_mode_speed_cap > `TRSL_SPEED_CAP_MAX) ?
		`TRSL_SPEED_CAP_MAX : torque_mode_speed_cap;
	assign int_lim = (cap_c > motor_max_speed) ? motor_max_speed : cap_c;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	auto_store_a : assert property (auto_offset_adjust && !servo_on |=>
		offset_value == $past(torque_ref_in)) else $error("auto not stored");
	auto_refuse_a : assert property (auto_offset_adjust && servo_on |=>
		offset_refused && $stable(offset_value)) else $error("auto not refused");
	refuse_cause_a : assert property (offset_refused |->
		$past(auto_offset_adjust && servo_on)) else $error("stray refusal");
	manual_store_a : assert property (manual_offset_adjust &&
		!auto_offset_adjust |=> offset_value == $past(manual_offset_value))
		else $error("manual not stored");
	cmd_source_a : assert property (torque_cmd != 16'h0000 |->
		$past(torque_mode_active) && torque_cmd == $past(torque_ref_monitor))
		else $error("command not from monitor");
	internal_limit_a : assert property (!speed_limit_source |=>
		speed_limit_eff == $past(int_lim)) else $error("internal limit wrong");
	external_limit_a : assert property (speed_limit_source |=>
		speed_limit_eff <= $past(int_lim)) else $error("external limit high");
	cap_fault_a : assert property (torque_mode_speed_cap >
		`TRSL_SPEED_CAP_MAX |=> param_fault) else $error("cap fault missing");
	cut_zero_a : assert property (speed_limiting |->
		torque_cmd == 16'h0000) else $error("torque not cut");
endmodule // trsl_monitor
bind trsl_core trsl_monitor u_mon (.sys_clk, .rst, .torque_mode_active,
	.servo_on, .torque_ref_in, .torque_mode_speed_cap, .speed_limit_source,
	.motor_max_speed, .auto_offset_adjust, .manual_offset_adjust,
	.manual_offset_value, .torque_cmd, .torque_ref_monitor, .speed_limit_eff,
	.speed_limiting, .offset_value, .offset_refused, .param_fault);
`default_nettype wire

// File: trsl_host.sv
// Host controller model driving the analog reference inputs
`default_nettype none
module trsl_host (
	input  wire logic        sys_clk,       // Clock
	input  wire logic [15:0] tref_set,      // Wanted torque ref, mV
	input  wire logic [15:0] vref_set,      // Wanted speed input, mV
	output var  logic [15:0] torque_ref_in, // Torque ref to device
	output var  logic [15:0] speed_ref_in   // Speed input to device
);
	timeunit 1ns;
	timeprecision 1ns;
	// Never asks for auto adjust itself, so no servolock loop is upset
	always @(posedge sys_clk) begin
		torque_ref_in <= tref_set;
		speed_ref_in <= vref_set;
	end
endmodule // trsl_host
`default_nettype wire

// File: trsl_core_tb.sv
// Testbench for the torque reference and speed limit block
`default_nettype none
module trsl_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        mode = 1'b1;
	logic        servo = 1'b0;
	logic        src = 1'b0;
	logic        auto_p = 1'b0;
	logic        man_p = 1'b0;
	logic [6:0]  tgain = 7'h1e;
	logic [12:0] cap = 13'h05dc;
	logic [12:0] mmax = 13'h1770;
	logic [11:0] sgain = 12'h096;
	logic [15:0] mspeed = 16'h0000;
	logic [15:0] man_v = 16'hffce;
	logic [15:0] tref_set = 16'h0000;
	logic [15:0] vref_set = 16'h0000;
	wire  [15:0] tref, vref, cmd, mon, offs;
	wire  [12:0] lim;
	wire         cut, refused, fault;
	int          num_errors = 0;
	int          comparisons = 0;
	always #20 sys_clk = ~sys_clk;
	trsl_host u_host (.sys_clk, .tref_set, .vref_set, .torque_ref_in(tref),
		.speed_ref_in(vref));
	trsl_core DUT (.sys_clk, .rst, .torque_mode_active(mode),
		.servo_on(servo), .torque_ref_in(tref), .speed_ref_in(vref),
		.torque_ref_gain(tgain), .torque_mode_speed_cap(cap),
		.speed_ref_gain(sgain), .speed_limit_source(src),
		.motor_max_speed(mmax), .motor_speed(mspeed),
		.auto_offset_adjust(auto_p), .manual_offset_adjust(man_p),
		.manual_offset_value(man_v), .torque_cmd(cmd),
		.torque_ref_monitor(mon), .speed_limit_eff(lim), .speed_limiting(cut),
		.offset_value(offs), .offset_refused(refused), .param_fault(fault));
	////////////////////////////////////////////////////////////////////////
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wait_n(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic torque(logic [6:0] g, logic [15:0] r, logic [15:0] m,
		logic [15:0] c);
		@(posedge sys_clk);
		tgain <= g;
		tref_set <= r;
		// Host delay plus two divider rounds plus the command stage
		wait_n(50);
		check("monitor", mon, m);
		check("command", cmd, c);
	endtask
	task automatic offset_req(logic a, logic r, logic [15:0] o);
		@(posedge sys_clk);
		auto_p <= a;
		man_p <= !a;
		@(posedge sys_clk);
		auto_p <= 1'b0;
		man_p <= 1'b0;
		#1;
		check("refused", {15'h0000, refused}, {15'h0000, r});
		check("offset", offs, o);
	endtask
	task automatic limit(logic s, logic [12:0] c, logic [12:0] m,
		logic [15:0] v, logic [12:0] e, logic f);
		@(posedge sys_clk);
		src <= s;
		cap <= c;
		mmax <= m;
		vref_set <= v;
		wait_n(70);
		check("limit", {3'h0, lim}, {3'h0, e});
		check("fault", {15'h0000, fault}, {15'h0000, f});
	endtask
	task automatic stop_test();
		if (num_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (11) @(posedge sys_clk);
		#1;
		check("reset limit", {3'h0, lim}, 16'h05dc);
		check("reset offset", offs, 16'h0000);
		check("reset command", cmd, 16'h0000);
		@(posedge sys_clk);
		rst <= 1'b0;
		torque(7'h1e, 16'h0bb8, 16'h03e8, 16'h03e8);
		torque(7'h1e, 16'h2328, 16'h0bb8, 16'h0bb8);
		torque(7'h1e, 16'hfed4, 16'hff9c, 16'hff9c);
		torque(7'h64, 16'h0bb8, 16'h012c, 16'h012c);
		torque(7'h05, 16'h0bb8, 16'h0bb8, 16'h0bb8);
		@(posedge sys_clk);
		mode <= 1'b0;
		torque(7'h1e, 16'h0bb8, 16'h03e8, 16'h0000);
		@(posedge sys_clk);
		mode <= 1'b1;
		torque(7'h1e, 16'h0019, 16'h0008, 16'h0008);
		offset_req(1'b1, 1'b0, 16'h0019);
		torque(7'h1e, 16'h0bd1, 16'h03e8, 16'h03e8);
		@(posedge sys_clk);
		servo <= 1'b1;
		offset_req(1'b1, 1'b1, 16'h0019);
		offset_req(1'b0, 1'b0, 16'hffce);
		torque(7'h1e, 16'h0bb8, 16'h03f8, 16'h03f8);
		@(posedge sys_clk);
		man_v <= 16'h0000;
		offset_req(1'b0, 1'b0, 16'h0000);
		limit(1'b0, 13'h07d0, 13'h0bb8, 16'h0000, 13'h07d0, 1'b0);
		limit(1'b0, 13'h1964, 13'h1f40, 16'h0000, 13'h1770, 1'b1);
		limit(1'b0, 13'h1388, 13'h0bb8, 16'h0000, 13'h0bb8, 1'b0);
		limit(1'b1, 13'h07d0, 13'h0bb8, 16'hf060, 13'h0258, 1'b0);
		limit(1'b1, 13'h01f4, 13'h0bb8, 16'h0fa0, 13'h01f4, 1'b0);
		@(posedge sys_clk);
		sgain <= 12'hfa0;
		limit(1'b1, 13'h1770, 13'h1770, 16'h03e8, 13'h0bb8, 1'b1);
		@(posedge sys_clk);
		sgain <= 12'h3e8;
		limit(1'b1, 13'h1770, 13'h1770, 16'hf830, 13'h07d0, 1'b0);
		limit(1'b0, 13'h03e8, 13'h0bb8, 16'h0000, 13'h03e8, 1'b0);
		@(posedge sys_clk);
		mspeed <= 16'h04b0;
		wait_n(5);
		check("cut", {15'h0000, cut}, 16'h0001);
		check("cut command", cmd, 16'h0000);
		@(posedge sys_clk);
		mspeed <= 16'hfb50;
		wait_n(5);
		check("braking", cmd, 16'h03e8);
		check("braking cut", {15'h0000, cut}, 16'h0000);
		torque(7'h1e, 16'hf448, 16'hfc18, 16'h0000);
		stop_test();
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		stop_test();
	end
endmodule // trsl_core_tb
`default_nettype wire
